// File: btb_cfg.svh
// constants for the bit-test branch execution unit
// How it works
// - set-branch on short-direct bit jumps to address plus 3 plus displacement
// - clear-branch on accumulator bit jumps to address plus 3 plus displacement, 8 clocks
// - clear-branch on status-word bit: 4 bytes, 11 clocks, target address plus 4
// - branch-and-clear on short-direct bit branches plus 4 and clears it, 10 or 12
// - branch-and-clear on status-word bit may change zero, aux-carry, carry; 12 clocks
// - branch-and-clear on pointer-pair bit takes 10, or 12 plus read and write waits outside high-speed ram
// - decrement B or C, branch plus 2 if nonzero; 2 bytes, 6 clocks
// - decrement short-direct byte, write back, branch plus 3 if nonzero; 8 or 10
// - interrupt enable sets master enable; 2 bytes, 6 clocks
// - interrupt disable clears master enable; 2 bytes, 6 clocks
// - one counted clock is one cpu clock picked by processor clock control
// - second count column whenever the access is outside high-speed ram
`ifndef BTB_CFG_SVH
`define BTB_CFG_SVH

// ==========================================================================
// memory map
`define BTB_SADDR_BASE    16'hFE20
`define BTB_SFR_BASE      16'hFF00
`define BTB_SADDR_SFR_OFS 8'hE0
`define BTB_HSRAM_LO      16'hFB00
`define BTB_HSRAM_HI      16'hFEFF

// ==========================================================================
// status word fields and reset values
`define BTB_PSW_IE_BIT    3'd7
`define BTB_PSW_RESET     8'h02
`define BTB_REG_RESET     8'h00
`define BTB_PC_RESET      16'h0000

// ==========================================================================
// instruction lengths in bytes
`define BTB_LEN2          3'd2
`define BTB_LEN3          3'd3
`define BTB_LEN4          3'd4

// ==========================================================================
// instruction clock counts
`define BTB_CLK6          7'd6
`define BTB_CLK8          7'd8
`define BTB_CLK9          7'd9
`define BTB_CLK10         7'd10
`define BTB_CLK11         7'd11
`define BTB_CLK12         7'd12

// ==========================================================================
// cpu clock prescaler, shift of 1 for each pcc code, capped at 4
`define BTB_PCC_MAX       3'd4

`endif

// File: btb_pkg.sv
// types for the bit-test branch execution unit
package btb_pkg;

   // ========================================================================
   // operations
   typedef enum logic [5:0] {
      OP_SET_BR   = 6'b00_0001,
      OP_CLR_BR   = 6'b00_0010,
      OP_CLR_BIT  = 6'b00_0100,
      OP_DEC_BR   = 6'b00_1000,
      OP_INT_EN   = 6'b01_0000,
      OP_INT_DIS  = 6'b10_0000
   } btb_op_type;

   // ========================================================================
   // operand sources
   typedef enum logic [6:0] {
      OPD_SADDR   = 7'b000_0001,
      OPD_SFR     = 7'b000_0010,
      OPD_ACC     = 7'b000_0100,
      OPD_PSW     = 7'b000_1000,
      OPD_PTR     = 7'b001_0000,
      OPD_REG_B   = 7'b010_0000,
      OPD_REG_C   = 7'b100_0000
   } btb_opd_type;

   // ========================================================================
   // core register and short-direct memory select for loads
   typedef enum logic [4:0] {
      LD_ACC      = 5'b0_0001,
      LD_REG_B    = 5'b0_0010,
      LD_REG_C    = 5'b0_0100,
      LD_PSW      = 5'b0_1000,
      LD_SADDR    = 5'b1_0000
   } btb_ld_type;

   typedef struct packed {
      btb_op_type  op;
      btb_opd_type opd;
      logic [2:0]  bit_sel;
      logic [7:0]  addr8;
      logic [7:0]  branch_displacement;
      logic [15:0] pc;
   } btb_instr_type;

   typedef struct packed {
      btb_ld_type  sel;
      logic [7:0]  addr8;
      logic [7:0]  data;
   } btb_load_type;

   typedef struct packed {
      logic [7:0]  acc;
      logic [7:0]  reg_b;
      logic [7:0]  reg_c;
      logic [7:0]  program_status_word;
   } btb_core_type;

endpackage

// File: btb_mem.sv
// short-direct data memory, 256 bytes, registered read
`timescale 1ns/1ps
`default_nettype none

module btb_mem (
   // clock, no reset
   input  wire logic       sys_clk_i,
   // write port
   input  wire logic       wr_en_i,
   input  wire logic [7:0] wr_addr_i,
   input  wire logic [7:0] wr_data_i,
   // read port
   input  wire logic [7:0] rd_addr_i,
   output logic      [7:0] rd_data_o
);

   logic [7:0] mem_reg [0:255];

   // ========================================================================
   // storage
   always_ff @(posedge sys_clk_i) begin
      if (wr_en_i) begin
         mem_reg[wr_addr_i] <= wr_data_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      rd_data_o <= mem_reg[rd_addr_i];
   end

endmodule

`default_nettype wire

// File: btb_exec.sv
// bit-test branch, decrement branch and interrupt control execution unit
`timescale 1ns/1ps
`default_nettype none
`include "btb_cfg.svh"

module btb_exec
   import btb_pkg::*;
(
   // clock and reset
   input  wire logic          sys_clk_i,
   input  wire logic          rst_n_i,
   // instruction request
   input  wire logic          instr_valid_i,
   input  wire btb_instr_type instr_i,
   output logic               instr_ready_o,
   output logic               done_o,
   output logic               taken_o,
   output logic        [15:0] pc_o,
   // timing control
   input  wire logic    [2:0] processor_clock_control_i,
   input  wire logic    [3:0] wait_rd_i,
   input  wire logic    [3:0] wait_wr_i,
   // operand pointer
   input  wire logic   [15:0] pointer_pair_i,
   // core register and short-direct memory load
   input  wire logic          ld_valid_i,
   input  wire btb_load_type  ld_i,
   output btb_core_type       core_o,
   output logic               master_interrupt_enable_o,
   // external data memory
   output logic        [15:0] dm_addr_o,
   output logic               dm_rd_o,
   output logic               dm_wr_o,
   output logic         [7:0] dm_wdata_o,
   input  wire logic    [7:0] dm_rdata_i
);

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_READ = 4'b0010,
      ST_EXEC = 4'b0100,
      ST_WAIT = 4'b1000
   } btb_state_type;

   // ========================================================================
   // functions
   function automatic logic [15:0] branch_target(input logic [15:0] pc, input logic [2:0] len,
                                                 input logic [7:0] disp);
      branch_target = pc + {13'h0000, len} + {{8{disp[7]}}, disp};
   endfunction

   function automatic logic is_hsram(input logic [15:0] addr);
      is_hsram = (addr >= `BTB_HSRAM_LO) && (addr <= `BTB_HSRAM_HI);
   endfunction

   // ========================================================================
   // state
   btb_state_type state_reg;
   btb_instr_type ins_reg;
   btb_core_type  core_reg;
   logic [15:0]   pc_reg;
   logic          taken_reg;
   logic [2:0]    len_reg;
   logic [6:0]    total_reg;
   logic [6:0]    clk_cnt_reg;
   logic [15:0]   presc_reg;
   logic          tick;
   logic [15:0]   dm_addr_reg;
   logic          dm_rd_reg;
   logic          dm_wr_reg;
   logic [7:0]    dm_wdata_reg;
   logic          use_mem_reg;
   logic [7:0]    mem_rdata;
   logic          mem_wr_en;
   logic [7:0]    mem_wr_addr;
   logic [7:0]    mem_wr_data;

   // ========================================================================
   // length and clock lookup for an incoming instruction
   logic [2:0]  len_next;
   logic [6:0]  total_next;
   logic [15:0] op_addr;
   logic        ext_dm;
   logic        col2;

   always_comb begin
      op_addr = `BTB_SADDR_BASE + {8'h00, instr_i.addr8};
      ext_dm  = 1'b0;
      col2    = 1'b0;
      case (instr_i.opd)
         OPD_SADDR: begin
            ext_dm = (instr_i.addr8 >= `BTB_SADDR_SFR_OFS);
            col2   = !is_hsram(op_addr);
         end
         OPD_SFR: begin
            op_addr = `BTB_SFR_BASE + {8'h00, instr_i.addr8};
            ext_dm  = 1'b1;
            col2    = 1'b1;
         end
         OPD_PTR: begin
            op_addr = pointer_pair_i;
            ext_dm  = 1'b1;
            col2    = !is_hsram(pointer_pair_i);
         end
         default: begin
            col2    = 1'b0;
         end
      endcase
   end

   always_comb begin
      len_next   = `BTB_LEN2;
      total_next = `BTB_CLK6;
      case (instr_i.op)
         OP_SET_BR: begin
            case (instr_i.opd)
               OPD_SADDR: begin
                  len_next   = `BTB_LEN3;
                  total_next = col2 ? `BTB_CLK9 : `BTB_CLK8;
               end
               OPD_SFR: begin
                  len_next   = `BTB_LEN4;
                  total_next = `BTB_CLK11;
               end
               OPD_PSW: begin
                  len_next   = `BTB_LEN3;
                  total_next = `BTB_CLK9;
               end
               OPD_PTR: begin
                  len_next   = `BTB_LEN3;
                  total_next = col2 ? (`BTB_CLK11 + {3'b000, wait_rd_i}) : `BTB_CLK10;
               end
               default: begin
                  len_next   = `BTB_LEN3;
                  total_next = `BTB_CLK8;
               end
            endcase
         end
         OP_CLR_BR: begin
            case (instr_i.opd)
               OPD_SADDR: begin
                  len_next   = `BTB_LEN4;
                  total_next = col2 ? `BTB_CLK11 : `BTB_CLK10;
               end
               OPD_SFR, OPD_PSW: begin
                  len_next   = `BTB_LEN4;
                  total_next = `BTB_CLK11;
               end
               OPD_PTR: begin
                  len_next   = `BTB_LEN3;
                  total_next = col2 ? (`BTB_CLK11 + {3'b000, wait_rd_i}) : `BTB_CLK10;
               end
               default: begin
                  len_next   = `BTB_LEN3;
                  total_next = `BTB_CLK8;
               end
            endcase
         end
         OP_CLR_BIT: begin
            case (instr_i.opd)
               OPD_SADDR: begin
                  len_next   = `BTB_LEN4;
                  total_next = col2 ? `BTB_CLK12 : `BTB_CLK10;
               end
               OPD_SFR, OPD_PSW: begin
                  len_next   = `BTB_LEN4;
                  total_next = `BTB_CLK12;
               end
               OPD_PTR: begin
                  len_next   = `BTB_LEN3;
                  total_next = col2 ? (`BTB_CLK12 + {3'b000, wait_rd_i} + {3'b000, wait_wr_i}) : `BTB_CLK10;
               end
               default: begin
                  len_next   = `BTB_LEN3;
                  total_next = `BTB_CLK8;
               end
            endcase
         end
         OP_DEC_BR: begin
            if (instr_i.opd == OPD_SADDR) begin
               len_next   = `BTB_LEN3;
               total_next = col2 ? `BTB_CLK10 : `BTB_CLK8;
            end else begin
               len_next   = `BTB_LEN2;
               total_next = `BTB_CLK6;
            end
         end
         default: begin
            len_next   = `BTB_LEN2;
            total_next = `BTB_CLK6;
         end
      endcase
   end

   // ========================================================================
   // sequencer
   logic accept;
   logic finish;

   assign accept        = (state_reg == ST_IDLE) && instr_valid_i;
   assign finish        = (state_reg == ST_WAIT) && (clk_cnt_reg == (total_reg - 7'h01)) && tick;
   assign instr_ready_o = (state_reg == ST_IDLE);
   assign done_o        = finish;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= ST_IDLE;
      end else begin
         case (state_reg)
            ST_IDLE: if (accept) state_reg <= ST_READ;
            ST_READ: state_reg <= ST_EXEC;
            ST_EXEC: state_reg <= ST_WAIT;
            ST_WAIT: if (finish) state_reg <= ST_IDLE;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ins_reg     <= '0;
         len_reg     <= `BTB_LEN2;
         total_reg   <= `BTB_CLK6;
         use_mem_reg <= 1'b0;
      end else if (accept) begin
         ins_reg     <= instr_i;
         len_reg     <= len_next;
         total_reg   <= total_next;
         use_mem_reg <= (instr_i.opd == OPD_SADDR) && !ext_dm;
      end
   end

   // ========================================================================
   // cpu clock prescaler and instruction clock counter
   assign tick = (presc_reg == ((16'h0001 << processor_clock_control_i) - 16'h0001)) ||
                 (processor_clock_control_i > `BTB_PCC_MAX && presc_reg == 16'h000F);

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         presc_reg   <= 16'h0000;
         clk_cnt_reg <= 7'h00;
      end else if (accept) begin
         presc_reg   <= 16'h0000;
         clk_cnt_reg <= 7'h00;
      end else if (state_reg != ST_IDLE) begin
         presc_reg <= tick ? 16'h0000 : presc_reg + 16'h0001;
         if (tick && clk_cnt_reg != total_reg) begin
            clk_cnt_reg <= clk_cnt_reg + 7'h01;
         end
      end
   end

   // ========================================================================
   // operand fetch and external data memory
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dm_addr_reg <= 16'h0000;
         dm_rd_reg   <= 1'b0;
      end else begin
         if (accept) begin
            dm_addr_reg <= op_addr;
         end
         dm_rd_reg <= accept && ext_dm;
      end
   end

   assign dm_addr_o  = dm_addr_reg;
   assign dm_rd_o    = dm_rd_reg;
   assign dm_wr_o    = dm_wr_reg;
   assign dm_wdata_o = dm_wdata_reg;

   btb_mem u_mem (
      .sys_clk_i (sys_clk_i),
      .wr_en_i   (mem_wr_en),
      .wr_addr_i (mem_wr_addr),
      .wr_data_i (mem_wr_data),
      .rd_addr_i (ins_reg.addr8),
      .rd_data_o (mem_rdata)
   );

   // ========================================================================
   // execute: operand, bit test, result
   logic [7:0] opv;
   logic [7:0] res;
   logic       bitv;
   logic       take;
   logic       wr_back;

   always_comb begin
      case (ins_reg.opd)
         OPD_ACC:   opv = core_reg.acc;
         OPD_PSW:   opv = core_reg.program_status_word;
         OPD_REG_B: opv = core_reg.reg_b;
         OPD_REG_C: opv = core_reg.reg_c;
         default:   opv = use_mem_reg ? mem_rdata : dm_rdata_i;
      endcase
      bitv    = opv[ins_reg.bit_sel];
      res     = opv;
      take    = 1'b0;
      wr_back = 1'b0;
      case (ins_reg.op)
         OP_SET_BR:  take = bitv;
         OP_CLR_BR:  take = !bitv;
         OP_CLR_BIT: begin
            take    = bitv;
            wr_back = bitv;
            res[ins_reg.bit_sel] = 1'b0;
         end
         OP_DEC_BR: begin
            res     = opv - 8'h01;
            take    = (res != 8'h00);
            wr_back = 1'b1;
         end
         default: take = 1'b0;
      endcase
   end

   assign mem_wr_en   = ld_valid_i && (ld_i.sel == LD_SADDR) ? 1'b1
                      : (state_reg == ST_EXEC) && wr_back && use_mem_reg;
   assign mem_wr_addr = (ld_valid_i && ld_i.sel == LD_SADDR) ? ld_i.addr8 : ins_reg.addr8;
   assign mem_wr_data = (ld_valid_i && ld_i.sel == LD_SADDR) ? ld_i.data : res;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dm_wr_reg    <= 1'b0;
         dm_wdata_reg <= 8'h00;
      end else begin
         dm_wr_reg <= (state_reg == ST_EXEC) && wr_back && !use_mem_reg &&
                      (ins_reg.opd == OPD_SADDR || ins_reg.opd == OPD_SFR || ins_reg.opd == OPD_PTR);
         if (state_reg == ST_EXEC) begin
            dm_wdata_reg <= res;
         end
      end
   end

   // ========================================================================
   // program counter
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pc_reg    <= `BTB_PC_RESET;
         taken_reg <= 1'b0;
      end else if (state_reg == ST_EXEC) begin
         taken_reg <= take;
         pc_reg    <= take ? branch_target(ins_reg.pc, len_reg, ins_reg.branch_displacement)
                           : ins_reg.pc + {13'h0000, len_reg};
      end
   end

   assign pc_o    = pc_reg;
   assign taken_o = taken_reg;

   // ========================================================================
   // core registers and interrupt enable
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         core_reg.acc                 <= `BTB_REG_RESET;
         core_reg.reg_b               <= `BTB_REG_RESET;
         core_reg.reg_c               <= `BTB_REG_RESET;
         core_reg.program_status_word <= `BTB_PSW_RESET;
      end else if (state_reg == ST_EXEC) begin
         case (ins_reg.op)
            OP_INT_EN:  core_reg.program_status_word[`BTB_PSW_IE_BIT] <= 1'b1;
            OP_INT_DIS: core_reg.program_status_word[`BTB_PSW_IE_BIT] <= 1'b0;
            default: begin
               if (wr_back) begin
                  case (ins_reg.opd)
                     OPD_ACC:   core_reg.acc                 <= res;
                     OPD_PSW:   core_reg.program_status_word <= res;
                     OPD_REG_B: core_reg.reg_b               <= res;
                     OPD_REG_C: core_reg.reg_c               <= res;
                     default:   core_reg.acc                 <= core_reg.acc;
                  endcase
               end
            end
         endcase
      end else if (ld_valid_i) begin
         case (ld_i.sel)
            LD_ACC:   core_reg.acc                 <= ld_i.data;
            LD_REG_B: core_reg.reg_b               <= ld_i.data;
            LD_REG_C: core_reg.reg_c               <= ld_i.data;
            LD_PSW:   core_reg.program_status_word <= ld_i.data;
            default:  core_reg.acc                 <= core_reg.acc;
         endcase
      end
   end

   assign core_o                    = core_reg;
   assign master_interrupt_enable_o = core_reg.program_status_word[`BTB_PSW_IE_BIT];

endmodule

`default_nettype wire

// File: btb_exec_sva.sv
// assertions for the bit-test branch execution unit
`timescale 1ns/1ps
`default_nettype none

module btb_exec_sva
   import btb_pkg::*;
(
   // clock and reset
   input wire logic          sys_clk_i,
   input wire logic          rst_n_i,
   // watched ports
   input wire logic          instr_valid_i,
   input wire btb_instr_type instr_i,
   input wire logic          instr_ready_o,
   input wire logic          done_o,
   input wire logic    [2:0] processor_clock_control_i,
   input wire logic          master_interrupt_enable_o,
   input wire logic          dm_rd_o,
   input wire logic          dm_wr_o
);
   // ====================
   // helpers
   default clocking @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   logic acc_any;
   logic acc_0;
   logic acc_bit;
   assign acc_any = instr_valid_i && instr_ready_o;
   assign acc_0   = acc_any && processor_clock_control_i == 3'h0;
   assign acc_bit = acc_0 && instr_i.opd == OPD_ACC && instr_i.op inside {OP_SET_BR, OP_CLR_BR, OP_CLR_BIT};

   // ====================
   // assertions
   chk_done_pulse: assert property (done_o |=> !done_o)
      else $error("done held too long");
   chk_ready_back: assert property (done_o |=> instr_ready_o)
      else $error("not ready after done");
   chk_busy_refuse: assert property (acc_any |=> !instr_ready_o [*5])
      else $error("ready while busy");
   chk_min_count: assert property (acc_any |=> !done_o [*5])
      else $error("done too early");
   chk_int_en_six: assert property (acc_0 && instr_i.op == OP_INT_EN |-> ##6 done_o && master_interrupt_enable_o)
      else $error("enable wrong");
   chk_int_dis_six: assert property (acc_0 && instr_i.op == OP_INT_DIS |-> ##6 done_o && !master_interrupt_enable_o)
      else $error("disable wrong");
   chk_dec_reg_six: assert property (acc_0 && instr_i.op == OP_DEC_BR && instr_i.opd inside {OPD_REG_B, OPD_REG_C} |-> ##6 done_o)
      else $error("register decrement count wrong");
   chk_acc_bit_eight: assert property (acc_bit |-> ##8 done_o)
      else $error("accumulator bit count wrong");
   chk_acc_no_mem: assert property (acc_bit |=> !(dm_rd_o || dm_wr_o) [*8])
      else $error("memory touched for accumulator");
   chk_psw_clear_br: assert property (acc_0 && instr_i.op == OP_CLR_BR && instr_i.opd == OPD_PSW |-> ##11 done_o)
      else $error("status clear-branch count wrong");
   chk_wr_pulse: assert property (dm_wr_o |=> !dm_wr_o)
      else $error("write strobe too long");

   // ====================
   // covers
   cover property (done_o && master_interrupt_enable_o);
   cover property (dm_wr_o);
   cover property (dm_rd_o);
endmodule

`default_nettype wire

// File: btb_dmem_model.sv
// behavioural data memory at the far side of the execution unit
`timescale 1ns/1ps
`default_nettype none

module btb_dmem_model (
   // clock
   input  wire logic        sys_clk_i,
   // request
   input  wire logic [15:0] dm_addr_i,
   input  wire logic        dm_rd_i,
   input  wire logic        dm_wr_i,
   input  wire logic  [7:0] dm_wdata_i,
   // answer
   output logic       [7:0] dm_rdata_o
);
   logic [7:0] mem [logic [15:0]];
   initial dm_rdata_o = 8'h00;
   // ====================
   // one cycle read, idle data keeps changing
   always @(posedge sys_clk_i) begin
      if (dm_wr_i)
         mem[dm_addr_i] = dm_wdata_i;
      if (dm_rd_i)
         dm_rdata_o <= mem.exists(dm_addr_i) ? mem[dm_addr_i] : 8'h00;
      else
         dm_rdata_o <= ~dm_rdata_o;
   end
   function automatic logic [7:0] peek(input logic [15:0] a);
      return mem[a];
   endfunction
   task automatic poke(input logic [15:0] a, input logic [7:0] d);
      mem[a] = d;
   endtask
endmodule

`default_nettype wire

// File: test_btb_exec.sv
// self-checking bench for the bit-test branch execution unit
`timescale 1ns/1ps
`default_nettype none

module test_btb_exec
   import btb_pkg::*;
   ;
   localparam logic [15:0] pb = 16'h0100;
   logic          clk = 0;
   logic          rst_n = 0;
   logic          vld = 0;
   logic          ld_vld = 0;
   btb_instr_type ins = '0;
   btb_load_type  ld = '0;
   logic    [2:0] processor_clock_control = 0;
   logic    [3:0] n_rd = 0;
   logic    [3:0] n_wr = 0;
   logic   [15:0] ptr = 0;
   logic          rdy, done, tk, mie, rd, wr;
   logic   [15:0] pc, da;
   logic    [7:0] wd, rdat;
   btb_core_type  core;
   int            errors = 0;
   int            tests_run = 0;

   always #25 clk = ~clk;

   btb_exec btb_exec_inst (.sys_clk_i(clk), .rst_n_i(rst_n), .instr_valid_i(vld), .instr_i(ins),
      .instr_ready_o(rdy), .done_o(done), .taken_o(tk), .pc_o(pc), .processor_clock_control_i(processor_clock_control),
      .wait_rd_i(n_rd), .wait_wr_i(n_wr), .pointer_pair_i(ptr), .ld_valid_i(ld_vld), .ld_i(ld),
      .core_o(core), .master_interrupt_enable_o(mie), .dm_addr_o(da), .dm_rd_o(rd), .dm_wr_o(wr),
      .dm_wdata_o(wd), .dm_rdata_i(rdat));
   btb_dmem_model btb_dmem_model_inst (.sys_clk_i(clk), .dm_addr_i(da), .dm_rd_i(rd), .dm_wr_i(wr),
      .dm_wdata_i(wd), .dm_rdata_o(rdat));

   // ====================
   // shared tasks
   task cmp(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task end_sim;
      if (errors == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task load(input btb_ld_type s, input logic [7:0] a, input logic [7:0] d);
      ld_vld = 1;
      ld = '{s, a, d};
      @(posedge clk);
      #1 ld_vld = 0;
   endtask
   function automatic logic [15:0] tgt(input int len, input logic [7:0] d);
      return pb + 16'(len) + {{8{d[7]}}, d};
   endfunction
   task run(input btb_instr_type i, input int clks, input logic [15:0] epc, input logic etk);
      int k;
      vld = 1;
      ins = i;
      @(posedge clk);
      #1 vld = 0;
      k = 1;
      while (done !== 1'b1 && k < 1000) begin
         @(posedge clk);
         #1 k++;
      end
      cmp(16'(k), 16'(clks));
      cmp(pc, epc);
      cmp({15'h0000, tk}, {15'h0000, etk});
      @(posedge clk);
      #1;
   endtask

   // ====================
   // scenarios
   task t_bt;
      load(LD_SADDR, 8'h20, 8'h08);
      run('{OP_SET_BR, OPD_SADDR, 3'h3, 8'h20, 8'hF0, pb}, 8, tgt(3, 8'hF0), 1);
      run('{OP_SET_BR, OPD_SADDR, 3'h2, 8'h20, 8'hF0, pb}, 8, pb + 16'h0003, 0);
      btb_dmem_model_inst.poke(16'h8000, 8'h80);
      n_rd = 2;
      ptr = 16'h8000;
      run('{OP_SET_BR, OPD_PTR, 3'h7, 8'h00, 8'h7F, pb}, 13, tgt(3, 8'h7F), 1);
      n_rd = 0;
   endtask
   task t_bf;
      load(LD_ACC, 8'h00, 8'hFE);
      run('{OP_CLR_BR, OPD_ACC, 3'h0, 8'h00, 8'h05, pb}, 8, tgt(3, 8'h05), 1);
      run('{OP_CLR_BR, OPD_ACC, 3'h1, 8'h00, 8'h05, pb}, 8, pb + 16'h0003, 0);
      run('{OP_CLR_BR, OPD_PSW, 3'h0, 8'h00, 8'h05, pb}, 11, tgt(4, 8'h05), 1);
      run('{OP_CLR_BR, OPD_PSW, 3'h1, 8'h00, 8'h05, pb}, 11, pb + 16'h0004, 0);
   endtask
   task t_branch_and_clear_bit;
      load(LD_SADDR, 8'h30, 8'h01);
      run('{OP_CLR_BIT, OPD_SADDR, 3'h0, 8'h30, 8'h80, pb}, 10, tgt(4, 8'h80), 1);
      run('{OP_CLR_BIT, OPD_SADDR, 3'h0, 8'h30, 8'h80, pb}, 10, pb + 16'h0004, 0);
      btb_dmem_model_inst.poke(16'hFF05, 8'h04);
      run('{OP_CLR_BIT, OPD_SADDR, 3'h2, 8'hE5, 8'h10, pb}, 12, tgt(4, 8'h10), 1);
      cmp({8'h00, btb_dmem_model_inst.peek(16'hFF05)}, 16'h0000);
      load(LD_PSW, 8'h00, 8'h43);
      run('{OP_CLR_BIT, OPD_PSW, 3'h6, 8'h00, 8'h10, pb}, 12, tgt(4, 8'h10), 1);
      cmp({8'h00, core.program_status_word}, 16'h0003);
      btb_dmem_model_inst.poke(16'h9000, 8'h11);
      n_rd = 2;
      n_wr = 3;
      ptr = 16'h9000;
      run('{OP_CLR_BIT, OPD_PTR, 3'h4, 8'h00, 8'h10, pb}, 17, tgt(3, 8'h10), 1);
      cmp({8'h00, btb_dmem_model_inst.peek(16'h9000)}, 16'h0001);
      n_rd = 0;
      n_wr = 0;
   endtask
   task t_decrement_branch_nonzero;
      load(LD_REG_B, 8'h00, 8'h02);
      run('{OP_DEC_BR, OPD_REG_B, 3'h0, 8'h00, 8'hFE, pb}, 6, tgt(2, 8'hFE), 1);
      run('{OP_DEC_BR, OPD_REG_B, 3'h0, 8'h00, 8'hFE, pb}, 6, pb + 16'h0002, 0);
      cmp({8'h00, core.reg_b}, 16'h0000);
      load(LD_REG_C, 8'h00, 8'h00);
      run('{OP_DEC_BR, OPD_REG_C, 3'h0, 8'h00, 8'h03, pb}, 6, tgt(2, 8'h03), 1);
      cmp({8'h00, core.reg_c}, 16'h00FF);
      load(LD_SADDR, 8'h40, 8'h03);
      run('{OP_DEC_BR, OPD_SADDR, 3'h0, 8'h40, 8'h03, pb}, 8, tgt(3, 8'h03), 1);
      btb_dmem_model_inst.poke(16'hFF05, 8'h01);
      run('{OP_DEC_BR, OPD_SADDR, 3'h0, 8'hE5, 8'h03, pb}, 10, pb + 16'h0003, 0);
      cmp({8'h00, btb_dmem_model_inst.peek(16'hFF05)}, 16'h0000);
   endtask
   task t_int;
      run('{OP_INT_EN, OPD_ACC, 3'h0, 8'h00, 8'h00, pb}, 6, pb + 16'h0002, 0);
      cmp({15'h0000, mie}, 16'h0001);
      run('{OP_INT_DIS, OPD_ACC, 3'h0, 8'h00, 8'h00, pb}, 6, pb + 16'h0002, 0);
      cmp({15'h0000, mie}, 16'h0000);
      processor_clock_control = 3'h2;
      run('{OP_INT_EN, OPD_ACC, 3'h0, 8'h00, 8'h00, pb}, 24, pb + 16'h0002, 0);
      processor_clock_control = 3'h0;
   endtask

   // ====================
   // main sequence and watchdog
   initial begin
      repeat (5) @(posedge clk);
      #1 rst_n = 1;
      t_bt;
      t_bf;
      t_branch_and_clear_bit;
      t_decrement_branch_nonzero;
      t_int;
      end_sim;
   end
   initial begin
      #(50 * 4000);
      errors++;
      end_sim;
   end
endmodule

bind btb_exec btb_exec_sva btb_exec_sva_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
   .instr_valid_i(instr_valid_i), .instr_i(instr_i), .instr_ready_o(instr_ready_o), .done_o(done_o),
   .processor_clock_control_i(processor_clock_control_i),
   .master_interrupt_enable_o(master_interrupt_enable_o), .dm_rd_o(dm_rd_o), .dm_wr_o(dm_wr_o));

`default_nettype wire
